// ==== core/rfbm_device.sv ====
// Purpose: 128-byte dual-port frame store with radio sequencing
// Assumes: baseband delivers bytes after the start delimiter only
// Notes:   the array has no reset; validity is tracked by a flag
//
// The placing of the registers and register access over Wishbone were decided locally.

`timescale 1ns/1ps

module rfbm_device #(
    parameter int DEPTH = rfbm_pkg::BUF_BYTES
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    rfbm_if.dev             cpu,
    input  wire logic       rx_sfd,
    input  wire logic       rx_byte_valid,
    input  wire logic [7:0] rx_byte,
    input  wire logic       rx_end_ok,
    input  wire logic       rx_end_bad,
    input  wire logic [7:0] rx_lqi,
    input  wire logic       ack_done,
    input  wire logic       tx_ready,
    output logic            tx_valid,
    output logic [7:0]      tx_data,
    output logic            tx_last
);
    localparam int AW = $clog2(DEPTH);

    // ****************************************************************
    // storage and state
    // ****************************************************************
    logic [7:0]            mem_q [DEPTH];
    rfbm_pkg::rfbm_state_t state_q;
    rfbm_pkg::rfbm_state_t state_d;
    logic                  valid_q;
    logic [7:0]            rdata_q;
    logic                  rvalid_q;
    logic                  rx_hdr_q;
    logic [AW-1:0]         rx_ptr_q;
    logic [7:0]            rx_phr_q;
    logic [7:0]            rx_len_q;
    logic                  rx_done_q;
    logic [7:0]            tx_idx_q;
    logic [7:0]            tx_len_q;
    logic                  tx_ret_q;
    logic                  tx_valid_q;
    logic [7:0]            tx_data_q;
    logic [15:0]           crc_q;

    // ****************************************************************
    // port decode
    // ****************************************************************
    wire access_ok = !cpu.power_gate &&
                     state_q != rfbm_pkg::ST_SLEEP;
    // only a real reception stores; acknowledgement wait just listens
    wire rx_store  = state_q == rfbm_pkg::ST_BUSY_RX;
    wire bb_we     = rx_store &&
                     ((rx_byte_valid && !rx_hdr_q) || rx_end_ok);
    wire [7:0] bb_wdata = rx_end_ok ? rx_lqi : rx_byte;
    wire clash     = bb_we && rx_ptr_q == cpu.addr[AW-1:0];
    wire cpu_we    = cpu.wr_en && access_ok && !clash;
    wire kill      = cpu.radio_reset || cpu.power_gate ||
                     state_d == rfbm_pkg::ST_SLEEP;

    // ****************************************************************
    // transmit fetch
    // ****************************************************************
    wire        tx_fire = tx_valid_q && tx_ready;
    wire        tx_end  = tx_fire && tx_idx_q == tx_len_q;
    wire [7:0]  tx_nidx = tx_idx_q + 8'h01;
    wire        use_fcs = cpu.auto_crc && tx_len_q >= 8'h02;
    wire [7:0]  fcs_lo  = tx_len_q - 8'h01;
    wire        in_fcs  = use_fcs && tx_idx_q >= fcs_lo;
    wire [15:0] crc_nx  = (tx_fire && tx_idx_q != 8'h00 && !in_fcs) ?
                          rfbm_pkg::rfbm_crc_byte(crc_q, tx_data_q) : crc_q;
    wire [7:0]  tx_next =
        (use_fcs && tx_nidx == fcs_lo)   ? crc_nx[7:0] :
        (use_fcs && tx_nidx == tx_len_q) ? crc_nx[15:8] :
        mem_q[tx_nidx[AW-1:0]];
    // a zero length byte still sends the length alone
    wire tx_go = state_q != rfbm_pkg::ST_BUSY_TX &&
                 state_d == rfbm_pkg::ST_BUSY_TX;

    assign tx_valid    = tx_valid_q;
    assign tx_data     = tx_data_q;
    assign tx_last     = tx_valid_q && tx_idx_q == tx_len_q;
    assign cpu.rdata   = rdata_q;
    assign cpu.rvalid  = rvalid_q;
    assign cpu.state   = state_q;
    assign cpu.rx_len  = rx_len_q;
    assign cpu.rx_done = rx_done_q;
    assign cpu.valid   = valid_q;

    // ****************************************************************
    // radio sequencing
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            rfbm_pkg::ST_SLEEP: begin
                if (cpu.cmd_valid && cpu.cmd == rfbm_pkg::CMD_OFF) begin
                    state_d = rfbm_pkg::ST_OFF;
                end
            end
            rfbm_pkg::ST_BUSY_RX: begin
                if (rx_end_ok || rx_end_bad) begin
                    state_d = rfbm_pkg::ST_RX_ON;
                end
            end
            rfbm_pkg::ST_BUSY_TX: begin
                if (tx_end) begin
                    state_d = tx_ret_q ? rfbm_pkg::ST_ACK_WAIT
                                       : rfbm_pkg::ST_SYNTH;
                end
            end
            rfbm_pkg::ST_ACK_WAIT: begin
                if (ack_done) begin
                    state_d = rfbm_pkg::ST_ARET_ON;
                end
            end
            default: begin
                if (cpu.cmd_valid) begin
                    case (cpu.cmd)
                        rfbm_pkg::CMD_OFF:     state_d = rfbm_pkg::ST_OFF;
                        rfbm_pkg::CMD_SYNTH:   state_d = rfbm_pkg::ST_SYNTH;
                        rfbm_pkg::CMD_RX_ON:   state_d = rfbm_pkg::ST_RX_ON;
                        rfbm_pkg::CMD_ARET_ON: state_d = rfbm_pkg::ST_ARET_ON;
                        rfbm_pkg::CMD_SLEEP:   state_d = rfbm_pkg::ST_SLEEP;
                        rfbm_pkg::CMD_TX_START: begin
                            if (state_q == rfbm_pkg::ST_SYNTH ||
                                state_q == rfbm_pkg::ST_ARET_ON) begin
                                state_d = rfbm_pkg::ST_BUSY_TX;
                            end
                        end
                        default: state_d = state_q;
                    endcase
                end else if (state_q == rfbm_pkg::ST_RX_ON && rx_sfd) begin
                    state_d = rfbm_pkg::ST_BUSY_RX;
                end
            end
        endcase
        // sleep may abort any activity
        if (cpu.cmd_valid && cpu.cmd == rfbm_pkg::CMD_SLEEP) begin
            state_d = rfbm_pkg::ST_SLEEP;
        end
        if (cpu.radio_reset || cpu.power_gate) begin
            state_d = rfbm_pkg::ST_OFF;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= rfbm_pkg::ST_OFF;
            valid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (kill) begin
                valid_q <= 1'b0;
            end else if (cpu_we || (rx_store && rx_end_ok)) begin
                valid_q <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // dual-port array, no reset: contents simply go stale
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (cpu_we) begin
            mem_q[cpu.addr[AW-1:0]] <= cpu.wdata;
        end
        // later write wins on a shared address
        if (bb_we) begin
            mem_q[rx_ptr_q] <= bb_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= cpu.rd_en;
            if (cpu.rd_en) begin
                rdata_q <= access_ok ? mem_q[cpu.addr[AW-1:0]] : 8'h00;
            end
        end
    end

    // ****************************************************************
    // receive path
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_hdr_q  <= 1'b1;
            rx_ptr_q  <= '0;
            rx_phr_q  <= 8'h00;
            rx_len_q  <= 8'h00;
            rx_done_q <= 1'b0;
        end else begin
            rx_done_q <= rx_store && rx_end_ok;
            if (state_d == rfbm_pkg::ST_BUSY_RX &&
                state_q != rfbm_pkg::ST_BUSY_RX) begin
                rx_hdr_q <= 1'b1;
                rx_ptr_q <= '0;
            end else if (rx_store && rx_byte_valid) begin
                if (rx_hdr_q) begin
                    rx_hdr_q <= 1'b0;
                    rx_phr_q <= rx_byte;
                end else begin
                    rx_ptr_q <= rx_ptr_q + 1'b1;
                end
            end
            if (rx_store && rx_end_ok) begin
                rx_len_q <= rx_phr_q;
            end
        end
    end

    // ****************************************************************
    // transmit path; rx writes and tx reads never overlap in time
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_idx_q   <= 8'h00;
            tx_len_q   <= 8'h00;
            tx_ret_q   <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_data_q  <= 8'h00;
            crc_q      <= rfbm_pkg::CRC_INIT;
        end else begin
            if (tx_go) begin
                tx_idx_q   <= 8'h00;
                tx_len_q   <= mem_q[0];
                tx_data_q  <= mem_q[0];
                tx_ret_q   <= state_q == rfbm_pkg::ST_ARET_ON;
                tx_valid_q <= 1'b1;
                crc_q      <= rfbm_pkg::CRC_INIT;
            end else if (state_d != rfbm_pkg::ST_BUSY_TX || tx_end) begin
                tx_valid_q <= 1'b0;
            end else if (tx_fire) begin
                tx_idx_q  <= tx_nidx;
                tx_data_q <= tx_next;
                crc_q     <= crc_nx;
            end
        end
    end

endmodule : rfbm_device

// ==== core/rfbm_pkg.sv ====
// Purpose: shared constants, types and checksum helper of the frame store
// Assumes: one 50 MHz clock, byte-wide buffer of 128 entries
// Notes:   register indexes are word indexes, byte address is four times
package rfbm_pkg;

    // ****************************************************************
    // buffer geometry
    // ****************************************************************
    localparam int BUF_BYTES = 128;
    localparam int BUF_AW    = 7;

    // ****************************************************************
    // register indexes on the software bus
    // ****************************************************************
    localparam logic [8:0] IDX_BUF_BASE = 9'h180;
    localparam logic [8:0] IDX_BUF_LAST = 9'h1ff;
    localparam logic [8:0] IDX_CTRL     = 9'h010;
    localparam logic [8:0] IDX_CMD      = 9'h011;
    localparam logic [8:0] IDX_STATUS   = 9'h012;
    localparam logic [8:0] IDX_RXLEN    = 9'h013;
    localparam logic [8:0] IDX_CRC      = 9'h014;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int CTRL_AUTO_LOCK = 0;
    localparam int CTRL_AUTO_CRC  = 1;
    localparam int CTRL_PWR_GATE  = 2;
    localparam int CMD_RESET_BIT  = 7;
    localparam int STAT_VALID_BIT = 3;
    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [15:0] CRC_INIT  = 16'h0000;
    localparam logic [15:0] CRC_POLY  = 16'h8408;

    // ****************************************************************
    // radio command field codes
    // ****************************************************************
    typedef logic [2:0] rfbm_cmd_t;
    localparam rfbm_cmd_t CMD_NOP      = 3'h0;
    localparam rfbm_cmd_t CMD_OFF      = 3'h1;
    localparam rfbm_cmd_t CMD_SYNTH    = 3'h2;
    localparam rfbm_cmd_t CMD_RX_ON    = 3'h3;
    localparam rfbm_cmd_t CMD_TX_START = 3'h4;
    localparam rfbm_cmd_t CMD_ARET_ON  = 3'h5;
    localparam rfbm_cmd_t CMD_SLEEP    = 3'h6;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_SYNTH,
        ST_RX_ON,
        ST_BUSY_RX,
        ST_ARET_ON,
        ST_BUSY_TX,
        ST_ACK_WAIT,
        ST_SLEEP
    } rfbm_state_t;

    // lsb-first ccitt checksum, one byte
    function automatic logic [15:0] rfbm_crc_byte(input logic [15:0] crc,
                                                  input logic [7:0]  data);
        logic [15:0] c;
        logic        fb;
        c  = crc;
        fb = 1'b0;
        for (int i = 0; i < 8; i++) begin
            fb = c[0] ^ data[i];
            c  = c >> 1;
            if (fb) begin
                c = c ^ CRC_POLY;
            end
        end
        return c;
    endfunction : rfbm_crc_byte

endpackage : rfbm_pkg

// ==== core/rfbm_if.sv ====
// Purpose: controller port between frame store and controller end
// Assumes: both ends on core_clk
// Notes:   rd_en, wr_en, cmd_valid, radio_reset, rx_done are pulses
`timescale 1ns/1ps
interface rfbm_if (
    input logic core_clk
);
    logic                       wr_en;
    logic                       rd_en;
    logic [rfbm_pkg::BUF_AW-1:0] addr;
    logic [7:0]                 wdata;
    logic [7:0]                 rdata;
    logic                       rvalid;
    logic                       cmd_valid;
    rfbm_pkg::rfbm_cmd_t        cmd;
    logic                       radio_reset;
    logic                       power_gate;
    logic                       auto_crc;
    rfbm_pkg::rfbm_state_t      state;
    logic [7:0]                 rx_len;
    logic                       rx_done;
    logic                       valid;

    modport dev (
        input  wr_en, rd_en, addr, wdata, cmd_valid, cmd, radio_reset,
        input  power_gate, auto_crc,
        output rdata, rvalid, state, rx_len, rx_done, valid
    );
    modport ctl (
        output wr_en, rd_en, addr, wdata, cmd_valid, cmd, radio_reset,
        output power_gate, auto_crc,
        input  rdata, rvalid, state, rx_len, rx_done, valid
    );
endinterface : rfbm_if

// ==== core/rfbm_host.sv ====
// Purpose: controller end, wishbone slave bridging software to the store
// Assumes: classic wishbone, 32-bit data, low byte used
// Notes:   buffer words answer in three edges, own registers in one
`timescale 1ns/1ps
module rfbm_host (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    rfbm_if.ctl              fb,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [10:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o
);
    typedef enum logic [1:0] {H_IDLE, H_WAIT, H_DONE} rfbm_hstate_t;

    // ****************************************************************
    // decode
    // ****************************************************************
    rfbm_hstate_t hs_q;
    logic         ack_q;
    logic [7:0]   dat_q;
    logic [7:0]   ctrl_q;
    logic [15:0]  crc_q;
    logic         wr_q;
    logic         rd_q;
    logic [6:0]   addr_q;
    logic [7:0]   wdata_q;
    logic         cmdv_q;
    rfbm_pkg::rfbm_cmd_t cmd_q;
    logic         rst_pulse_q;

    wire [8:0] idx     = wb_adr_i[10:2];
    wire       req     = wb_cyc_i && wb_stb_i && !ack_q;
    wire       wr_ok   = wb_we_i && wb_sel_i[0];
    wire       is_buf  = (idx >= rfbm_pkg::IDX_BUF_BASE);
    wire       busy    = (fb.state == rfbm_pkg::ST_BUSY_RX) ||
                         (fb.state == rfbm_pkg::ST_BUSY_TX);
    wire       hit_cmd = req && wr_ok && idx == rfbm_pkg::IDX_CMD;
    wire       lock_go = fb.rx_done && ctrl_q[rfbm_pkg::CTRL_AUTO_LOCK];
    wire [7:0] stat    = {4'h0, fb.valid, fb.state};
    wire [7:0] reg_rd  =
        (idx == rfbm_pkg::IDX_CTRL)   ? ctrl_q :
        (idx == rfbm_pkg::IDX_STATUS) ? stat :
        (idx == rfbm_pkg::IDX_RXLEN)  ? fb.rx_len :
        (idx == rfbm_pkg::IDX_CRC)    ? crc_q[7:0] : 8'h00;

    assign wb_ack_o       = ack_q;
    assign wb_dat_o       = {24'h0, dat_q};
    assign fb.wr_en       = wr_q;
    assign fb.rd_en       = rd_q;
    assign fb.addr        = addr_q;
    assign fb.wdata       = wdata_q;
    assign fb.cmd_valid   = cmdv_q;
    assign fb.cmd         = cmd_q;
    assign fb.radio_reset = rst_pulse_q;
    assign fb.power_gate  = ctrl_q[rfbm_pkg::CTRL_PWR_GATE];
    assign fb.auto_crc    = ctrl_q[rfbm_pkg::CTRL_AUTO_CRC];

    // ****************************************************************
    // bus sequencing
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_q    <= H_IDLE;
            ack_q   <= 1'b0;
            dat_q   <= 8'h00;
            ctrl_q  <= rfbm_pkg::CTRL_RST;
            crc_q   <= rfbm_pkg::CRC_INIT;
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
            addr_q  <= 7'h00;
            wdata_q <= 8'h00;
        end else begin
            ack_q <= 1'b0;
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            case (hs_q)
                H_IDLE: begin
                    // buffer access waits while the radio owns the store
                    if (req && is_buf && !busy) begin
                        wr_q    <= wr_ok;
                        rd_q    <= !wb_we_i;
                        addr_q  <= idx[6:0];
                        wdata_q <= wb_dat_i[7:0];
                        hs_q    <= H_WAIT;
                    end else if (req && !is_buf) begin
                        ack_q <= 1'b1;
                        dat_q <= wb_we_i ? 8'h00 : reg_rd;
                        if (wr_ok && idx == rfbm_pkg::IDX_CTRL) begin
                            ctrl_q <= wb_dat_i[7:0];
                        end
                        if (wr_ok && idx == rfbm_pkg::IDX_CRC) begin
                            crc_q <= rfbm_pkg::CRC_INIT;
                        end
                    end
                end
                H_WAIT: begin
                    hs_q <= H_DONE;
                end
                H_DONE: begin
                    ack_q <= 1'b1;
                    dat_q <= wb_we_i ? 8'h00 : fb.rdata;
                    if (!wb_we_i) begin
                        crc_q <= rfbm_pkg::rfbm_crc_byte(crc_q, fb.rdata);
                    end
                    hs_q <= H_IDLE;
                end
                default: hs_q <= H_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // radio commands
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdv_q      <= 1'b0;
            cmd_q       <= rfbm_pkg::CMD_NOP;
            rst_pulse_q <= 1'b0;
        end else begin
            cmdv_q      <= 1'b0;
            rst_pulse_q <= 1'b0;
            if (lock_go) begin
                cmdv_q <= 1'b1;
                cmd_q  <= rfbm_pkg::CMD_SYNTH;
            end else if (hit_cmd) begin
                cmdv_q <= wb_dat_i[2:0] != rfbm_pkg::CMD_NOP;
                cmd_q  <= wb_dat_i[2:0];
            end
            if (hit_cmd) begin
                rst_pulse_q <= wb_dat_i[rfbm_pkg::CMD_RESET_BIT];
            end
        end
    end

endmodule : rfbm_host

// ==== tb/rfbm_monitor.sv ====
// Purpose: port assertions of the frame store
// Assumes: one clock, reset active low
// Notes:   watches the interface signals only
`timescale 1ns/1ps
module rfbm_monitor (
    input logic                  core_clk,
    input logic                  rst_n,
    input logic                  rd_en,
    input logic [7:0]            rdata,
    input logic                  rvalid,
    input logic                  cmd_valid,
    input rfbm_pkg::rfbm_cmd_t   cmd,
    input logic                  radio_reset,
    input logic                  power_gate,
    input rfbm_pkg::rfbm_state_t state,
    input logic                  rx_done,
    input logic                  valid
);
    // ********
    // checks
    // ********
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // gate and reset override sleep, so leave them out
    wire slp = cmd_valid && cmd == rfbm_pkg::CMD_SLEEP && !power_gate
               && !radio_reset;
    property p_rd; rd_en |=> rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read unanswered");
    property p_gz; rvalid && $past(power_gate) |-> rdata == 8'h00; endproperty
    a_gz: assert property (p_gz) else $error("gated read data");
    property p_sz;
        rvalid && $past(state) == rfbm_pkg::ST_SLEEP |-> rdata == 8'h00;
    endproperty
    a_sz: assert property (p_sz) else $error("sleep read data");
    property p_gi; power_gate |=> !valid; endproperty
    a_gi: assert property (p_gi) else $error("valid under gate");
    property p_ri; radio_reset |=> !valid; endproperty
    a_ri: assert property (p_ri) else $error("valid after reset");
    property p_ss; slp |=> state == rfbm_pkg::ST_SLEEP; endproperty
    a_ss: assert property (p_ss) else $error("sleep not entered");
    property p_si; slp |=> !valid; endproperty
    a_si: assert property (p_si) else $error("valid after sleep");
    property p_dp; rx_done |=> !rx_done; endproperty
    a_dp: assert property (p_dp) else $error("rx_done too long");
    property p_ds; rx_done |-> $past(state) == rfbm_pkg::ST_BUSY_RX; endproperty
    a_ds: assert property (p_ds) else $error("rx_done source");
    c_rx: cover property (rx_done);
    c_sl: cover property (slp);
    c_rd: cover property (rvalid && rdata != 8'h00);
endmodule : rfbm_monitor

// ==== tb/rfbm_tb.sv ====
// Purpose: bench for controller bridge and frame store
// Assumes: 50 MHz clock, bench is wishbone master and baseband
// Notes:   bad-frame input tied low; stb follows cyc
`timescale 1ns/1ps
module rfbm_tb;
    // ********
    // wiring
    // ********
    logic        core_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0, ack;
    logic        sfd = 1'b0, bv = 1'b0, eo = 1'b0, ackd = 1'b0, rdy = 1'b0;
    logic        tv, tl;
    logic [10:0] adr = 11'h000;
    logic [31:0] wd = 32'h0, rq;
    logic [7:0]  rb = 8'h00, lqi = 8'h00, td, q;
    logic [7:0]  txe[5];
    logic [15:0] crc;
    int          error_cnt = 0, check_count = 0, cyc_cnt = 0, k;
    always #10 core_clk = ~core_clk;
    rfbm_if fbi (.core_clk(core_clk));
    rfbm_host i_rfbm_host (.core_clk(core_clk), .rst_n(rst_n), .fb(fbi),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(wd), .wb_sel_i(4'h1), .wb_dat_o(rq), .wb_ack_o(ack));
    rfbm_device i_rfbm_device (.core_clk(core_clk), .rst_n(rst_n),
        .cpu(fbi), .rx_sfd(sfd), .rx_byte_valid(bv), .rx_byte(rb),
        .rx_end_ok(eo), .rx_end_bad(1'b0), .rx_lqi(lqi), .ack_done(ackd),
        .tx_ready(rdy), .tx_valid(tv), .tx_data(td), .tx_last(tl));
    rfbm_monitor i_rfbm_monitor (.core_clk(core_clk), .rst_n(rst_n),
        .rd_en(fbi.rd_en), .rdata(fbi.rdata), .rvalid(fbi.rvalid),
        .cmd_valid(fbi.cmd_valid), .cmd(fbi.cmd), .state(fbi.state),
        .radio_reset(fbi.radio_reset), .power_gate(fbi.power_gate),
        .rx_done(fbi.rx_done), .valid(fbi.valid));
    // ********
    // tasks
    // ********
    task automatic chk(input string nm, input logic [7:0] e, g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [8:0] idx, logic [7:0] d);
        @(posedge core_clk);
        cyc <= 1'b1;
        we  <= w;
        adr <= {idx, 2'b00};
        wd  <= {24'h0, d};
        // ack ends this wait; only the bench timeout ends it if ack never comes
        do @(posedge core_clk);
        while (ack !== 1'b1);
        q = rq[7:0];
        cyc <= 1'b0;
    endtask : wb
    task automatic rd(input logic [8:0] idx, input logic [7:0] e, m);
        wb(1'b0, idx, 8'h00);
        chk($sformatf("index %h", idx), e, q & m);
    endtask : rd
    task automatic st(input logic [7:0] e, m);
        rd(rfbm_pkg::IDX_STATUS, e, m);
    endtask : st
    task automatic cmd(input rfbm_pkg::rfbm_cmd_t c);
        wb(1'b1, rfbm_pkg::IDX_CMD, {5'h00, c});
    endtask : cmd
    task automatic bufchk(input logic [7:0] e[$]);
        foreach (e[i]) rd(rfbm_pkg::IDX_BUF_BASE + 9'(i), e[i], 8'hff);
    endtask : bufchk
    // gap first, so a command just written has reached the radio
    task automatic rx(input logic [7:0] b[$], logic [7:0] l, logic ed);
        logic got;
        got = 1'b0;
        repeat (3) @(posedge core_clk);
        sfd <= 1'b1;
        rb  <= 8'hee;
        @(posedge core_clk);
        sfd <= 1'b0;
        bv  <= 1'b1;
        rb  <= 8'(b.size());
        foreach (b[i]) begin
            @(posedge core_clk);
            rb <= b[i];
        end
        @(posedge core_clk);
        bv  <= 1'b0;
        eo  <= 1'b1;
        lqi <= l;
        repeat (4) begin
            @(posedge core_clk);
            eo <= 1'b0;
            if (fbi.rx_done === 1'b1) got = 1'b1;
        end
        chk("rx_done", {7'h0, ed}, {7'h0, got});
    endtask : rx
    function automatic logic [15:0] crc_upd(logic [15:0] c, logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ rfbm_pkg::CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc_upd
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    always @(posedge core_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // ********
    // sequence
    // ********
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        st(8'h00, 8'hff);
        wb(1'b1, rfbm_pkg::IDX_BUF_LAST, 8'ha5);
        wb(1'b1, rfbm_pkg::IDX_BUF_BASE, 8'h5a);
        bufchk('{8'h5a});
        rd(rfbm_pkg::IDX_BUF_LAST, 8'ha5, 8'hff);
        rd(9'h0f0, 8'h00, 8'hff);
        cmd(rfbm_pkg::CMD_RX_ON);
        rx('{8'ha1, 8'ha2, 8'ha3}, 8'h5c, 1'b1);
        rd(rfbm_pkg::IDX_RXLEN, 8'h03, 8'hff);
        bufchk('{8'ha1, 8'ha2, 8'ha3, 8'h5c});
        rd(rfbm_pkg::IDX_BUF_LAST, 8'ha5, 8'hff);
        wb(1'b1, rfbm_pkg::IDX_CTRL, 8'h01);
        rx('{8'hb7}, 8'h11, 1'b1);
        st(8'h09, 8'hff);
        bufchk('{8'hb7, 8'h11, 8'ha3});
        cmd(rfbm_pkg::CMD_SYNTH);
        rx('{8'hc1, 8'hc2}, 8'h77, 1'b0);
        bufchk('{8'hb7, 8'h11});
        st(8'h09, 8'hff);
        wb(1'b1, rfbm_pkg::IDX_CTRL, 8'h02);
        crc = crc_upd(crc_upd(rfbm_pkg::CRC_INIT, 8'h3c), 8'hc5);
        txe = '{8'h04, 8'h3c, 8'hc5, crc[7:0], crc[15:8]};
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, rfbm_pkg::IDX_BUF_BASE + 9'(i), txe[i]);
        end
        cmd(rfbm_pkg::CMD_ARET_ON);
        cmd(rfbm_pkg::CMD_TX_START);
        k = 0;
        // even count of toggles leaves ready low at the end
        repeat (100) begin
            @(posedge core_clk);
            if (tv === 1'b1 && rdy && k < 5) begin
                chk("tx byte", txe[k], td);
                chk("tx last", {7'h0, k == 4}, {7'h0, tl});
                k++;
            end
            rdy <= ~rdy;
        end
        chk("tx count", 8'h05, k[7:0]);
        st(8'h06, 8'h07);
        rx('{8'hd1}, 8'h22, 1'b0);
        wb(1'b1, rfbm_pkg::IDX_CRC, 8'h00);
        bufchk('{8'h04, 8'h3c});
        crc = crc_upd(crc_upd(rfbm_pkg::CRC_INIT, 8'h04), 8'h3c);
        rd(rfbm_pkg::IDX_CRC, crc[7:0], 8'hff);
        @(posedge core_clk);
        ackd <= 1'b1;
        @(posedge core_clk);
        ackd <= 1'b0;
        st(8'h04, 8'h07);
        wb(1'b1, rfbm_pkg::IDX_CMD, 8'h80);
        st(8'h00, 8'h08);
        cmd(rfbm_pkg::CMD_SLEEP);
        st(8'h07, 8'hff);
        bufchk('{8'h00});
        wb(1'b1, rfbm_pkg::IDX_CTRL, 8'h04);
        bufchk('{8'h00});
        st(8'h00, 8'h07);
        print_verdict();
    end
endmodule : rfbm_tb
